// *** inc/sfe_params.svh ***
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Pin synchroniser layout
// ----------------------------------------------------------------------------
`define SFE_IX_SCK    0
`define SFE_IX_SI     1
`define SFE_IX_CS     2
`define SFE_IX_HOLD   3
`define SFE_PIN_W     4
// Chip select and pause are inactive high, so their stages reset to one.
`define SFE_SYNC_RST  4'hC

// ----------------------------------------------------------------------------
// Framing constants
// ----------------------------------------------------------------------------
`define SFE_BIT_LAST  3'h7
`define SFE_PROG_MAX  9'h100

`endif

// *** inc/sfe_pkg.sv ***
package sfe_pkg;

  // --------------------------------------------------------------------------
  // Link state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SFE_IDLE   = 3'b001,
    SFE_ACTIVE = 3'b010,
    SFE_PAUSE  = 3'b100
  } sfe_state_e;

endpackage

// *** logic/sfe_front_end.sv ***
`timescale 1ns/1ps
`include "sfe_params.svh"
module sfe_front_end
  import sfe_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sck,
  input  wire logic       cs_b,
  input  wire logic       si,
  input  wire logic       hold_b,
  output logic            so,
  output logic            so_oe,
  input  wire logic [7:0] tx_byte,
  input  wire logic       out_en,
  input  wire logic       prog_data,
  input  wire logic       busy,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            frame_start,
  output logic            frame_end,
  output logic            selected,
  output logic            standby,
  output logic            prog_overflow
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [`SFE_PIN_W-1:0] pin_raw;
  logic [`SFE_PIN_W-1:0] pin_meta;
  logic [`SFE_PIN_W-1:0] pin_s;

  assign pin_raw = {hold_b, cs_b, si, sck};

  // Reset value of every stage, one bit per pin, so no false select follows reset.
  localparam logic [`SFE_PIN_W-1:0] SYNC_RST = `SFE_SYNC_RST;

  // Two stages per pin; the first stage feeds only the second.
  genvar gi;
  generate
    for (gi = 0; gi < `SFE_PIN_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_meta[gi] <= SYNC_RST[gi];
          pin_s[gi]    <= SYNC_RST[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_s[gi]    <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic sck_s;
  logic si_s;
  logic cs_s;
  logic hold_s;

  assign sck_s  = pin_s[`SFE_IX_SCK];
  assign si_s   = pin_s[`SFE_IX_SI];
  assign cs_s   = pin_s[`SFE_IX_CS];
  assign hold_s = pin_s[`SFE_IX_HOLD];

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  logic sck_d;
  logic cs_d;

  // Clock and data share the same delay, so data sampled on a detected edge is aligned.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_d  <= cs_s;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  // Only edges matter, so an idle-high clock (mode 3) and idle-low clock (mode 0) both work.
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign cs_fall  = ~cs_s & cs_d;
  assign cs_rise  = cs_s & ~cs_d;

  // --------------------------------------------------------------------------
  // Link state and shifters
  // --------------------------------------------------------------------------
  sfe_state_e state;
  sfe_state_e next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [6:0] rx_shift;
  logic [6:0] next_rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic       load_pend;
  logic       next_load_pend;
  logic [8:0] prog_cnt;
  logic [8:0] next_prog_cnt;
  logic       next_so;
  logic       next_so_oe;
  logic [7:0] next_rx_byte;
  logic       next_rx_valid;
  logic       next_frame_start;
  logic       next_frame_end;
  logic       next_standby;
  logic       next_selected;
  logic       next_prog_overflow;

  // Next-state logic for the whole link; rise and fall edges never coincide.
  always_comb begin
    next_state         = state;
    next_bit_cnt       = bit_cnt;
    next_rx_shift      = rx_shift;
    next_tx_shift      = tx_shift;
    next_load_pend     = load_pend;
    next_prog_cnt      = prog_cnt;
    next_so            = so;
    next_rx_byte       = rx_byte;
    next_rx_valid      = 1'b0;
    next_frame_start   = 1'b0;
    next_frame_end     = 1'b0;
    next_prog_overflow = prog_overflow;
    unique case (state)
      SFE_IDLE: begin
        // Input bits are not looked at here at all.
        if (cs_fall) begin
          next_state         = SFE_ACTIVE;
          next_frame_start   = 1'b1;
          next_bit_cnt       = 3'h0;
          next_prog_cnt      = 9'h000;
          next_prog_overflow = 1'b0;
          next_load_pend     = 1'b0;
          next_tx_shift      = 8'h00;
        end
      end
      SFE_ACTIVE: begin
        if (cs_rise) begin
          next_state     = SFE_IDLE;
          next_frame_end = 1'b1;
        end else if (!hold_s) begin
          next_state = SFE_PAUSE;
        end else if (sck_rise) begin
          next_rx_shift = {rx_shift[5:0], si_s};
          next_bit_cnt  = bit_cnt + 3'h1;
          if (bit_cnt == `SFE_BIT_LAST) begin
            next_rx_byte   = {rx_shift, si_s};
            next_load_pend = 1'b1;
            if (prog_data && (prog_cnt == `SFE_PROG_MAX)) begin
              next_prog_overflow = 1'b1;
            end else begin
              next_rx_valid = 1'b1;
              if (prog_data) begin
                next_prog_cnt = prog_cnt + 9'h001;
              end
            end
          end
        end else if (sck_fall) begin
          // The core gets half a clock period after rx_valid to present tx_byte.
          if (load_pend) begin
            next_so        = tx_byte[7];
            next_tx_shift  = {tx_byte[6:0], 1'b0};
            next_load_pend = 1'b0;
          end else begin
            next_so       = tx_shift[7];
            next_tx_shift = {tx_shift[6:0], 1'b0};
          end
        end
      end
      SFE_PAUSE: begin
        // Clock and data are ignored; framing resumes where it stopped.
        if (cs_rise) begin
          next_state     = SFE_IDLE;
          next_frame_end = 1'b1;
        end else if (hold_s) begin
          next_state = SFE_ACTIVE;
        end
      end
    endcase
    next_so_oe   = (next_state == SFE_ACTIVE) && out_en;
    next_standby = (next_state == SFE_IDLE) && !busy;
    next_selected = (next_state != SFE_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= SFE_IDLE;
      bit_cnt       <= 3'h0;
      rx_shift      <= 7'h00;
      tx_shift      <= 8'h00;
      load_pend     <= 1'b0;
      prog_cnt      <= 9'h000;
      so            <= 1'b0;
      so_oe         <= 1'b0;
      rx_byte       <= 8'h00;
      rx_valid      <= 1'b0;
      frame_start   <= 1'b0;
      frame_end     <= 1'b0;
      selected      <= 1'b0;
      standby       <= 1'b0;
      prog_overflow <= 1'b0;
    end else begin
      state         <= next_state;
      bit_cnt       <= next_bit_cnt;
      rx_shift      <= next_rx_shift;
      tx_shift      <= next_tx_shift;
      load_pend     <= next_load_pend;
      prog_cnt      <= next_prog_cnt;
      so            <= next_so;
      so_oe         <= next_so_oe;
      rx_byte       <= next_rx_byte;
      rx_valid      <= next_rx_valid;
      frame_start   <= next_frame_start;
      frame_end     <= next_frame_end;
      selected      <= next_selected;
      standby       <= next_standby;
      prog_overflow <= next_prog_overflow;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  desel_hiz_a: assert property ((state == SFE_IDLE) |-> !so_oe && !selected)
    else $error("Output driven while deselected.");
  ignore_si_a: assert property ((state == SFE_IDLE) |=> $stable(rx_shift) && !rx_valid)
    else $error("Input latched while deselected.");
  start_frame_a: assert property ((state == SFE_IDLE) && cs_fall |=> frame_start && bit_cnt == 3'h0 ##1 !frame_start)
    else $error("Frame start not one pulse after chip select fall.");
  end_frame_a: assert property ((state != SFE_IDLE) && cs_rise |=> frame_end && !selected && !so_oe)
    else $error("Frame not ended on chip select rise.");
  standby_busy_a: assert property (busy |=> !standby)
    else $error("Standby shown while busy.");
  sample_rise_a: assert property ((state == SFE_ACTIVE) && hold_s && !cs_rise && sck_rise |=> rx_shift[0] == $past(si_s))
    else $error("Input bit not taken on rising clock.");
  drive_fall_a: assert property ($changed(so) |-> $past(sck_fall) && $past(state) == SFE_ACTIVE)
    else $error("Output changed away from a falling clock.");
  prog_cap_a: assert property (rx_valid && $past(prog_data) |-> prog_cnt <= `SFE_PROG_MAX && prog_cnt != 9'h000)
    else $error("Program byte count out of range.");
  pause_hold_a: assert property ((state == SFE_PAUSE) |-> !so_oe ##1 $stable(bit_cnt) && !rx_valid)
    else $error("Activity during pause.");
  msb_first_a: assert property (rx_valid |-> rx_byte[7:1] == $past(rx_shift))
    else $error("Received byte not most significant bit first.");

  frame_c: cover property (frame_start ##[1:1000] rx_valid ##[1:1000] frame_end);
  pause_c: cover property ((state == SFE_ACTIVE) ##1 (state == SFE_PAUSE) ##[1:300] (state == SFE_ACTIVE));
  overflow_c: cover property ($rose(prog_overflow));
  busy_end_c: cover property (frame_end && busy);

endmodule

// *** testbench/sfe_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------------------
module sfe_host (
  input  wire logic clk,
  input  wire       so_w,
  output logic      sck,
  output logic      cs_b,
  output logic      si,
  output logic      hold_b
);
  // The link idles with the clock parked low, deselected and not paused.
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    hold_b = 1'b1;
  end
  // Half a link clock period is 16 system cycles.
  task automatic half();
    repeat (16) @(negedge clk);
  endtask
  // A falling chip select opens a frame.
  task automatic start();
    cs_b = 1'b0;
    half();
  endtask
  // The data line toggles once released, so no stale bit can pass for a valid one.
  task automatic stop();
    half();
    cs_b = 1'b1;
    si = ~si;
    half();
  endtask
  // One byte each way in mode 0; data is set up while the clock is low.
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      si = d[i];
      half();
      sck = 1'b1;
      q[i] = so_w;
      half();
      sck = 1'b0;
    end
  endtask
  // One byte each way in mode 3; the clock idles high and every bit opens with a fall.
  task automatic xbyte3(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = d[i];
      half();
      sck = 1'b1;
      q[i] = so_w;
      half();
    end
  endtask
  // Parks the clock at its idle level; only done while deselected.
  task automatic park(input logic lvl);
    sck = lvl;
    half();
  endtask
  // Pause changes only while the clock is low.
  task automatic hold(input logic lvl);
    hold_b = lvl;
    half();
  endtask
  // A lone clock pulse, used inside a pause where it must be ignored.
  task automatic pulse();
    sck = 1'b1;
    half();
    sck = 1'b0;
    half();
  endtask
endmodule

// *** testbench/serial_flash_spi_front_end_bench.sv ***
`timescale 1ns/1ps
module serial_flash_spi_front_end_bench;
  logic        clk, rst_b, sck, cs_b, si, hold_b, so, so_oe, out_en, prog_data, busy;
  logic        rx_valid, frame_start, frame_end, selected, standby, prog_overflow;
  logic [7:0]  tx_byte, rx_byte, q;
  logic [15:0] rx_cnt = '0, fs_cnt = '0, fe_cnt = '0, base;
  int          num_errors = 0, tests_run = 0;
  wire         so_w;
  // ----------------------------------------------------------------------------
  // Clock, wire resolution and instances
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  assign so_w = so_oe ? so : 1'bz;
  sfe_host host_u (.clk(clk), .so_w(so_w), .sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b));
  sfe_front_end dut_u (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b),
    .so(so), .so_oe(so_oe), .tx_byte(tx_byte), .out_en(out_en), .prog_data(prog_data), .busy(busy),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .frame_start(frame_start), .frame_end(frame_end),
    .selected(selected), .standby(standby), .prog_overflow(prog_overflow));
  // Pulses are counted so a check never has to land in their single cycle.
  always @(posedge clk) begin
    if (rx_valid) rx_cnt <= rx_cnt + 16'h0001;
    if (frame_start) fs_cnt <= fs_cnt + 16'h0001;
    if (frame_end) fe_cnt <= fe_cnt + 16'h0001;
  end
  // ----------------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  // Clocking a byte while deselected must leave nothing behind.
  task automatic test_idle();
    check(standby, 1'b1);
    check(so_oe, 1'b0);
    host_u.xbyte(8'hFF, q);
    check(rx_cnt, 16'h0000);
    check(selected, 1'b0);
  endtask
  // A reply byte only appears in the byte after the one that triggered it.
  task automatic test_frame();
    tx_byte = 8'hA5;
    out_en = 1'b1;
    host_u.start();
    check(fs_cnt, 16'h0001);
    check(so_oe, 1'b1);
    host_u.xbyte(8'h3C, q);
    check(rx_byte, 8'h3C);
    host_u.xbyte(8'h81, q);
    check(q, 8'hA5);
    check(rx_byte, 8'h81);
    host_u.stop();
    check(fe_cnt, 16'h0001);
    check(selected, 1'b0);
    check(so_oe, 1'b0);
  endtask
  // A clock pulse inside a pause must not shift a bit in.
  task automatic test_pause();
    host_u.start();
    host_u.hold(1'b0);
    check(so_oe, 1'b0);
    check(selected, 1'b1);
    host_u.pulse();
    host_u.hold(1'b1);
    host_u.xbyte(8'h5A, q);
    check(rx_byte, 8'h5A);
    host_u.stop();
  endtask
  // Standby waits for a running timed operation.
  task automatic test_busy();
    busy = 1'b1;
    host_u.start();
    host_u.stop();
    check(standby, 1'b0);
    busy = 1'b0;
    repeat (4) @(negedge clk);
    check(standby, 1'b1);
  endtask
  // Mode 3 host: the clock idles high, yet bytes land and the reply still leads with its top bit.
  task automatic test_mode3();
    tx_byte = 8'hC3;
    out_en = 1'b1;
    host_u.park(1'b1);
    host_u.start();
    host_u.xbyte3(8'h96, q);
    check(rx_byte, 8'h96);
    host_u.xbyte3(8'h00, q);
    check(q, 8'hC3);
    check(rx_byte, 8'h00);
    host_u.stop();
    check(selected, 1'b0);
    host_u.park(1'b0);
  endtask
  // The 257th program byte is dropped and flagged until the next frame.
  task automatic test_overflow();
    prog_data = 1'b1;
    host_u.start();
    base = rx_cnt;
    for (int i = 0; i < 256; i++) host_u.xbyte(i[7:0], q);
    check(prog_overflow, 1'b0);
    check(rx_cnt, base + 16'h0100);
    host_u.xbyte(8'hEE, q);
    check(prog_overflow, 1'b1);
    check(rx_cnt, base + 16'h0100);
    host_u.stop();
    prog_data = 1'b0;
    host_u.start();
    check(prog_overflow, 1'b0);
    host_u.stop();
  endtask
  // The scenarios take about 68,000 cycles; the watchdog allows 90,000.
  initial begin
    #450000;
    num_errors++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    tx_byte = 8'h00;
    out_en = 1'b0;
    prog_data = 1'b0;
    busy = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    test_idle();
    test_frame();
    test_pause();
    test_busy();
    test_mode3();
    test_overflow();
    results();
  end
endmodule
